/* rtl/e1_framer_map.svh */
// register map, field positions, reset values and frame counts of the e1 framer
`ifndef E1_FRAMER_MAP_SVH
`define E1_FRAMER_MAP_SVH
`define A_CTRL      8'h00
`define A_TXSW      8'h04
`define A_STAT      8'h08
`define A_FEC       8'h0C
`define CTRL_RST    12'h000
`define TXSW_RST    12'h0FB
`define C_THR4      0
`define C_SVCDIS    1
`define C_ALARM_SIGNAL_DISABLE      2
`define C_AUTORA    3
`define C_FAREN     4
`define C_FRS       5
`define C_TT0       6
`define C_FREE      7
`define C_RFS       8
`define C_RX_INTERWORKING_SELECT     10
`define C_XFS       11
`define T_SIS       0
`define T_SIF       1
`define T_RA        2
`define T_NAT       3
`define T_MSIF      8
`define T_MSIS      9
`define T_MRA       10
`define T_MNAT      11
`define S_LFA       0
`define S_LFAST     1
`define S_FARST     2
`define S_MONST     3
`define S_ONES      4
`define S_SHORT     5
`define S_RA        6
`define S_NAT       8
`define FAS_WORD    7'h1B
`define FRAME_LAST  8'hFF
`define TS0_LAST    8'h07
`define ZERO_LIMIT  6'h1F
`define FEC_MAX     16'hFFFF
`endif

/* rtl/e1_framer_pkg.sv */
// types of the e1 doubleframe framer
package e1_framer_pkg;
	typedef enum logic [1:0] {ST_SRCH, ST_NFAS, ST_FAS2, ST_SYNC} sync_t;
	typedef struct packed {
		logic [11:0] ctrl;
		logic [11:0] txsw;
		logic [31:0] rdata;
		logic [7:0]  tx_pos;
		logic        tx_fas;
		logic        tx_bit;
		logic        pol;
		logic        line_a;
		logic        line_b;
		logic        oe_n;
		logic [5:0]  zero_run;
		logic        ones_fault;
		logic        short;
		logic        mon_st;
		logic [7:0]  sr;
		logic [7:0]  rx_pos;
		sync_t       fsm;
		logic        fas_exp;
		logic [2:0]  fas_bad;
		logic [2:0]  nfas_bad;
		logic [15:0] fec;
		logic        loss_of_alignment;
		logic        lfa_st;
		logic        far_st;
		logic        rx_ra;
		logic [4:0]  rx_nat;
		logic        rx_out;
	} state_t;
endpackage

/* rtl/e1_doubleframe_framer.sv */
// e1 doubleframe framer: ts0 synthesis, receive alignment, transmit line monitor
//Function
//- compare driven line pulses with monitor inputs
//- shorted line puts both outputs high impedance
//- over 31 zeros flags fault, monitor event
//- frame is 256 bits, 32 slots of 8
//- slot numbers pass through unchanged
//- doubleframe after reset, separate format fields
//- service word holds Si, A, Sa4..Sa8
//- service word bit 2 sent as one
//- remote alarm bit zero normally, one alarmed
//- full ts0 transparency takes ts0 from input
//- masks pass Si, A, Sa fields through
//- alignment flag and framing error counter
//- loss after 3 or 4 bad words
//- bad service word when bit 2 zero
//- loss of alignment sets sticky status
//- out of alignment freezes counts and status
//- out of alignment sends all ones, disableable
//- resync automatic, forced resync via control
//- sync needs fas, service, fas sequence
//- failed check restarts search after fas
//- recovery sets enabled sticky status
//- auto remote alarm follows loss of alignment
`timescale 1ns/1ns
`default_nettype none
`include "e1_framer_map.svh"
module e1_doubleframe_framer
	import e1_framer_pkg::*;
(
	// clock, reset and line bit strobe
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_bit_en,
	// transmit side
	input  wire logic        i_tx_system_data_in,
	output var  logic        o_tx_line_out_a,
	output var  logic        o_tx_line_out_b,
	output var  logic        o_tx_line_oe_n,
	input  wire logic        i_tx_monitor_in_a,
	input  wire logic        i_tx_monitor_in_b,
	// receive side
	input  wire logic        i_rx_line_data,
	output var  logic        o_rx_sys_data,
	output var  logic        o_loss_of_alignment,
	// register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output var  logic [31:0] o_rdata
);
	state_t r;
	state_t n;

	logic       b;
	logic       nat_now;
	logic       wr_ctrl;
	logic       wr_txsw;
	logic       wr_stat;
	logic       force_resync;
	logic       mon_ev;
	logic [7:0] nsr;
	logic [2:0] thr;

	always_comb begin
		n = r;
		b = 1'b0;
		nat_now = 1'b0;
		nsr = {r.sr[6:0], i_rx_line_data};
		thr = r.ctrl[`C_THR4] ? 3'h4 : 3'h3;
		wr_ctrl = i_wr && (i_addr == `A_CTRL);
		wr_txsw = i_wr && (i_addr == `A_TXSW);
		wr_stat = i_wr && (i_addr == `A_STAT);
		force_resync = wr_ctrl && i_wdata[`C_FRS];
		mon_ev = 1'b0;
		// register writes; force resync is a pulse and never stored
		if (wr_ctrl) begin
			n.ctrl = i_wdata[11:0] & ~(12'h001 << `C_FRS);
		end
		if (wr_txsw) begin
			n.txsw = i_wdata[11:0];
		end
		n.rdata = 32'h0000_0000;
		if (i_rd) begin
			unique case (i_addr)
				`A_CTRL: n.rdata = {20'h0_0000, r.ctrl};
				`A_TXSW: n.rdata = {20'h0_0000, r.txsw};
				`A_STAT: n.rdata = {19'h0_0000, r.rx_nat, 1'b0, r.rx_ra, r.short, r.ones_fault,
					r.mon_st, r.far_st, r.lfa_st, r.loss_of_alignment};
				`A_FEC:  n.rdata = {16'h0000, r.fec};
				default: n.rdata = 32'h0000_0000;
			endcase
		end
		// transmit ts0 synthesis; other slots pass with the same number
		if (r.tx_pos <= `TS0_LAST && !r.ctrl[`C_TT0]) begin
			if (r.tx_fas) begin
				if (r.tx_pos == 8'h00) begin
					b = r.txsw[`T_MSIF] ? i_tx_system_data_in : r.txsw[`T_SIF];
				end else begin
					b = 1'(`FAS_WORD >> (3'h7 - r.tx_pos[2:0]));
				end
			end else begin
				unique case (r.tx_pos[2:0])
					3'h0: b = r.txsw[`T_MSIS] ? i_tx_system_data_in : r.txsw[`T_SIS];
					3'h1: b = 1'b1;
					3'h2: begin
						if (r.txsw[`T_MRA]) begin
							b = i_tx_system_data_in;
						end else if (r.ctrl[`C_AUTORA]) begin
							b = r.loss_of_alignment;
						end else begin
							b = r.txsw[`T_RA];
						end
					end
					default: begin
						nat_now = r.txsw[`T_NAT + 32'(r.tx_pos[2:0]) - 3];
						b = r.txsw[`T_MNAT] ? i_tx_system_data_in : nat_now;
					end
				endcase
			end
		end else begin
			b = i_tx_system_data_in;
		end
		if (i_bit_en) begin
			// 256 bit frames, fas and service frames alternate
			n.tx_pos = r.tx_pos + 8'h01;
			if (r.tx_pos == `FRAME_LAST) begin
				n.tx_fas = ~r.tx_fas;
			end
			n.tx_bit = b;
			// ami on two rails; a short must not be fed further pulses
			n.line_a = b && !r.pol && !r.short;
			n.line_b = b && r.pol && !r.short;
			if (b) begin
				n.pol = ~r.pol;
			end
			// a driven rail that the monitor does not see back means a short
			if (!r.oe_n && (r.line_a != i_tx_monitor_in_a || r.line_b != i_tx_monitor_in_b)) begin
				n.short = 1'b1;
			end
			if (b) begin
				n.zero_run = 6'h00;
				n.ones_fault = 1'b0;
			end else if (r.zero_run != 6'h3F) begin
				n.zero_run = r.zero_run + 6'h01;
			end
			if (!b && r.zero_run >= `ZERO_LIMIT) begin
				n.ones_fault = 1'b1;
			end
			// receive path, one bit of latency, ais while unaligned
			n.rx_out = (r.loss_of_alignment && !r.ctrl[`C_ALARM_SIGNAL_DISABLE]) ? 1'b1 : i_rx_line_data;
			n.sr = nsr;
			n.rx_pos = r.rx_pos + 8'h01;
			unique case (r.fsm)
				ST_SRCH: begin
					if (nsr[6:0] == `FAS_WORD) begin
						n.rx_pos = `TS0_LAST;
						n.fsm = ST_NFAS;
					end
				end
				ST_NFAS: begin
					if (n.rx_pos == `TS0_LAST) begin
						n.fsm = nsr[6] ? ST_FAS2 : ST_SRCH;
					end
				end
				ST_FAS2: begin
					if (n.rx_pos == `TS0_LAST) begin
						if (nsr[6:0] == `FAS_WORD) begin
							n.fsm = ST_SYNC;
							n.loss_of_alignment = 1'b0;
							n.fas_exp = 1'b0;
							n.fas_bad = 3'h0;
							n.nfas_bad = 3'h0;
							n.far_st = r.far_st || r.ctrl[`C_FAREN];
						end else begin
							n.fsm = ST_SRCH;
						end
					end
				end
				ST_SYNC: begin
					if (n.rx_pos == `TS0_LAST) begin
						n.fas_exp = ~r.fas_exp;
						if (r.fas_exp) begin
							if (nsr[6:0] == `FAS_WORD) begin
								n.fas_bad = 3'h0;
							end else begin
								n.fas_bad = r.fas_bad + 3'h1;
								if (r.fec != `FEC_MAX) begin
									n.fec = r.fec + 16'h0001;
								end
							end
						end else begin
							n.rx_ra = nsr[5];
							n.rx_nat = nsr[4:0];
							if (nsr[6] || r.ctrl[`C_SVCDIS]) begin
								n.nfas_bad = 3'h0;
							end else begin
								n.nfas_bad = r.nfas_bad + 3'h1;
							end
						end
						if (n.fas_bad >= thr || n.nfas_bad >= thr) begin
							n.fsm = ST_SRCH;
							n.loss_of_alignment = 1'b1;
							n.lfa_st = 1'b1;
						end
					end
				end
			endcase
		end
		// forced resync drops alignment; search restarts at once
		if (force_resync && r.fsm != ST_SRCH) begin
			n.fsm = ST_SRCH;
			if (!r.loss_of_alignment) begin
				n.lfa_st = 1'b1;
			end
			n.loss_of_alignment = 1'b1;
		end
		mon_ev = (n.ones_fault && !r.ones_fault) || (n.short && !r.short);
		// status clears by writing one; a new event in the same cycle wins
		if (wr_stat) begin
			n.lfa_st = n.lfa_st && !(i_wdata[`S_LFAST] && !(n.loss_of_alignment && !r.loss_of_alignment));
			n.far_st = n.far_st && !(i_wdata[`S_FARST] && !(n.fsm == ST_SYNC && r.fsm != ST_SYNC));
			n.mon_st = r.mon_st && !i_wdata[`S_MONST];
			if (i_wdata[`S_SHORT] && !(n.short && !r.short)) begin
				n.short = 1'b0;
			end
		end
		if (mon_ev) begin
			n.mon_st = 1'b1;
		end
		n.oe_n = n.short;
		// a latched short keeps both rails low so nothing drives into the fault
		if (n.short) begin
			n.line_a = 1'b0;
			n.line_b = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '{ctrl: `CTRL_RST, txsw: `TXSW_RST, fsm: ST_SRCH, loss_of_alignment: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	assign o_tx_line_out_a = r.line_a;
	assign o_tx_line_out_b = r.line_b;
	assign o_tx_line_oe_n = r.oe_n;
	assign o_rx_sys_data = r.rx_out;
	assign o_loss_of_alignment = r.loss_of_alignment;
	assign o_rdata = r.rdata;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// line monitor and drive protection
	a_short_hiz: assert property (r.short |-> r.oe_n && !r.line_a && !r.line_b)
		else $error("short did not release the line");

	a_short_sticky: assert property (r.short && !(wr_stat && i_wdata[`S_SHORT]) |=> r.short)
		else $error("short latch dropped without clear");

	a_rails_excl: assert property (!(r.line_a && r.line_b))
		else $error("both rails driven at once");

	a_ones_run: assert property ($rose(r.ones_fault) |-> r.zero_run == 6'h20 && !r.tx_bit)
		else $error("ones fault not after 32 zeros");

	a_ones_clear: assert property (i_bit_en && b |=> !r.ones_fault && r.zero_run == 6'h00)
		else $error("ones fault not cleared by a mark");

	a_zero_count: assert property (i_bit_en && !b && r.zero_run != 6'h3F |=>
		r.zero_run == $past(r.zero_run) + 6'h01)
		else $error("zero run not counted");

	a_mon_event: assert property ($rose(r.ones_fault) || $rose(r.short) |-> r.mon_st)
		else $error("monitor event not flagged");

	a_mon_hold: assert property (r.mon_st && !(wr_stat && i_wdata[`S_MONST]) |=> r.mon_st)
		else $error("monitor status lost without clear");

	// frame timing and slot mapping
	a_idle_frozen: assert property (!i_bit_en |=> $stable(r.tx_pos) && $stable(r.rx_pos) && $stable(r.rx_out))
		else $error("bit state moved without strobe");

	a_frame_wrap: assert property (i_bit_en && r.tx_pos == `FRAME_LAST |=>
		r.tx_pos == 8'h00 && r.tx_fas != $past(r.tx_fas))
		else $error("frame did not wrap after 256 bits");

	a_pass_through: assert property (i_bit_en && r.tx_pos > `TS0_LAST && !r.short |=>
		r.short || (r.line_a || r.line_b) == $past(i_tx_system_data_in))
		else $error("payload slot not passed through");

	a_ts0_transp: assert property (i_bit_en && r.tx_pos <= `TS0_LAST && r.ctrl[`C_TT0] && !r.short |=>
		r.short || (r.line_a || r.line_b) == $past(i_tx_system_data_in))
		else $error("transparent ts0 not from input");

	// service and alignment word synthesis
	a_svc_bit: assert property (i_bit_en && !r.tx_fas && r.tx_pos == 8'h01 && !r.ctrl[`C_TT0] |=> r.tx_bit)
		else $error("service bit 2 not one");

	a_fas_ones: assert property (i_bit_en && r.tx_fas && !r.ctrl[`C_TT0] &&
		(r.tx_pos == 8'h03 || r.tx_pos == 8'h04 || r.tx_pos == 8'h06 || r.tx_pos == 8'h07) |=> r.tx_bit)
		else $error("alignment word one bit wrong");

	a_fas_zeros: assert property (i_bit_en && r.tx_fas && !r.ctrl[`C_TT0] &&
		(r.tx_pos == 8'h01 || r.tx_pos == 8'h02 || r.tx_pos == 8'h05) |=> !r.tx_bit)
		else $error("alignment word zero bit wrong");

	a_alarm_manual: assert property (i_bit_en && !r.tx_fas && r.tx_pos == 8'h02 && !r.ctrl[`C_TT0] && !i_wr
		&& !r.txsw[`T_MRA] && !r.ctrl[`C_AUTORA] |=> r.tx_bit == r.txsw[`T_RA])
		else $error("remote alarm bit not from register");

	a_auto_alarm: assert property (i_bit_en && !r.tx_fas && r.tx_pos == 8'h02 && !r.ctrl[`C_TT0]
		&& !r.txsw[`T_MRA] && r.ctrl[`C_AUTORA] |=> r.tx_bit == $past(r.loss_of_alignment))
		else $error("auto remote alarm wrong");

	a_nat_field: assert property (i_bit_en && !r.tx_fas && r.tx_pos == 8'h03 && !r.ctrl[`C_TT0] && !i_wr
		&& !r.txsw[`T_MNAT] |=> r.tx_bit == r.txsw[`T_NAT])
		else $error("first national bit not from register");

	a_nat_mask: assert property (i_bit_en && !r.tx_fas && r.tx_pos >= 8'h03 && r.tx_pos <= `TS0_LAST
		&& !r.ctrl[`C_TT0] && r.txsw[`T_MNAT] |=> r.tx_bit == $past(i_tx_system_data_in))
		else $error("masked national bit not from input");

	// receive alignment
	a_sync_path: assert property ($rose(r.fsm == ST_SYNC) |-> $past(r.fsm) == ST_FAS2 && !r.loss_of_alignment)
		else $error("sync reached without full check");

	a_lfa_state: assert property (r.loss_of_alignment == (r.fsm != ST_SYNC))
		else $error("loss flag disagrees with state");

	a_loss_flag: assert property ($past(r.fsm) == ST_SYNC && r.fsm == ST_SRCH |-> r.loss_of_alignment && r.lfa_st)
		else $error("loss of alignment not flagged");

	a_loss_search: assert property ($rose(r.loss_of_alignment) |-> r.fsm == ST_SRCH)
		else $error("search not restarted on loss");

	a_frs_drop: assert property (r.fsm == ST_SYNC && force_resync |=> r.loss_of_alignment && r.lfa_st)
		else $error("forced resync did not drop alignment");

	a_sync_clear: assert property ($fell(r.loss_of_alignment) |-> r.fas_bad == 3'h0 && r.nfas_bad == 3'h0)
		else $error("bad word counters not clear at sync");

	a_fas_good: assert property (i_bit_en && r.fsm == ST_SYNC && r.rx_pos == 8'h06 && r.fas_exp
		&& nsr[6:0] == `FAS_WORD |=> r.fas_bad == 3'h0)
		else $error("good alignment word kept bad count");

	a_thr_loss: assert property (r.fsm == ST_SYNC |-> r.fas_bad < 3'h4 && r.nfas_bad < 3'h4)
		else $error("bad word count past threshold");

	a_fec_frozen: assert property ($past(r.loss_of_alignment) && r.loss_of_alignment |-> $stable(r.fec) && $stable(r.rx_nat))
		else $error("counts moved while unaligned");

	a_rx_frozen: assert property (r.loss_of_alignment |=> $stable(r.rx_nat) && $stable(r.rx_ra))
		else $error("received service bits moved while unaligned");

	a_fec_step: assert property (!$stable(r.fec) |-> r.fec == $past(r.fec) + 16'h0001)
		else $error("error counter jumped");

	a_fec_sat: assert property (r.fec == `FEC_MAX |=> r.fec == `FEC_MAX)
		else $error("error counter wrapped");

	a_stat_read: assert property (i_rd && i_addr == `A_STAT |=> o_rdata[`S_LFA] == $past(r.loss_of_alignment))
		else $error("status read lost loss flag");

	a_far_enable: assert property (!r.ctrl[`C_FAREN] && !i_wr && !r.far_st |=> !r.far_st)
		else $error("recovery status set while disabled");

	a_ais_out: assert property (i_bit_en && r.loss_of_alignment && !r.ctrl[`C_ALARM_SIGNAL_DISABLE] |=> r.rx_out)
		else $error("ais not sent while unaligned");
endmodule
`default_nettype wire

/* tb/e1_line_partner.sv */
// far-end e1 line model: framed receive stream and transmit monitor return
`timescale 1ns/1ns
`default_nettype none
module e1_line_partner (
	// line bit timing
	input  wire logic i_clk,
	input  wire logic i_bit_en,
	// scenario controls
	input  wire logic i_fas_ok,
	input  wire logic i_svc_ok,
	input  wire logic i_short,
	// line side
	input  wire logic i_line_a,
	input  wire logic i_line_b,
	output var  logic o_rx_line,
	output var  logic o_mon_a,
	output var  logic o_mon_b
);
	logic [8:0] pos = 9'h000;
	logic [7:0] ts0;
	// odd frames carry the fas word, even ones the service word; payload 8'hfe never mimics fas
	always_comb ts0 = pos[8] ? {7'h4D, i_fas_ok} : {1'b1, i_svc_ok, 6'h1F};
	always @(posedge i_clk)
		if (i_bit_en) begin
			pos <= pos + 9'h001;
			o_rx_line <= (pos[7:3] == 5'h00) ? ts0[~pos[2:0]] : ~&pos[2:0];
		end
	// a shorted primary shows as a return that disagrees with what is driven
	always_comb begin
		o_mon_a = i_line_a ^ i_short;
		o_mon_b = i_line_b;
	end
endmodule
`default_nettype wire

/* tb/e1_doubleframe_framer_tb_top.sv */
// self-checking bench of the e1 doubleframe framer
`timescale 1ns/1ns
`default_nettype none
`include "e1_framer_map.svh"
module e1_doubleframe_framer_tb_top;
	logic        i_clk, i_rst_n, i_sys, i_wr, i_rd;
	logic        i_bit_en = 1'b0;
	logic        fas_ok, svc_ok, short_on, rx, ma, mb, la, lb, oe_n, rxs, loa;
	logic [1:0]  ph = 2'h0;
	logic [8:0]  txc;
	logic [7:0]  i_addr, svc, fas;
	logic [31:0] i_wdata, rdata, v, f0;
	int          err_count, n_compared, n;
	e1_doubleframe_framer e1_doubleframe_framer_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bit_en(i_bit_en),
		.i_tx_system_data_in(i_sys), .o_tx_line_out_a(la), .o_tx_line_out_b(lb), .o_tx_line_oe_n(oe_n),
		.i_tx_monitor_in_a(ma), .i_tx_monitor_in_b(mb), .i_rx_line_data(rx), .o_rx_sys_data(rxs),
		.o_loss_of_alignment(loa), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata));
	e1_line_partner e1_line_partner_i (.i_clk(i_clk), .i_bit_en(i_bit_en), .i_fas_ok(fas_ok), .i_svc_ok(svc_ok),
		.i_short(short_on), .i_line_a(la), .i_line_b(lb), .o_rx_line(rx), .o_mon_a(ma), .o_mon_b(mb));
	initial i_clk = 1'b0;
	always #10 i_clk = ~i_clk;
	// bit strobe every fourth cycle keeps frames short in simulation time
	always @(posedge i_clk) begin
		ph <= ph + 2'h1;
		i_bit_en <= (ph == 2'h3);
	end
	// rails seen at a strobe belong to the previous position; ts0 bit 1 lands in the msb
	always @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n) txc <= 9'h1FF;
		else if (i_bit_en) begin
			txc <= txc + 9'h001;
			if (txc[7:3] == 5'h00 && txc[8]) fas[~txc[2:0]] <= la | lb;
			if (txc[7:3] == 5'h00 && !txc[8]) svc[~txc[2:0]] <= la | lb;
		end
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = rdata;
	endtask
	// bounded wait on the alignment flag, n ends as the cycles spent
	task automatic wloa(input logic e);
		n = 0;
		while (loa !== e && n < 12000) begin
			@(posedge i_clk);
			n++;
		end
		chk("loss flag", loa, e);
		if (n >= 12000) test_done;
	endtask
	initial begin
		i_rst_n = 1'b0;
		{i_wr, i_rd, i_addr, i_wdata} = '0;
		{i_sys, fas_ok, svc_ok, short_on} = 4'hE;
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		chk("loss at reset", loa, 1'b1);
		rd(`A_CTRL);
		chk("ctrl", v, 32'h0000_0000);
		rd(`A_TXSW);
		chk("txsw", v, 32'h0000_00FB);
		rd(8'h10);
		chk("unmapped", v, 32'h0000_0000);
		wr(`A_CTRL, 32'h0000_0018);
		n = 0;
		repeat (2000) @(posedge i_clk) n += (rxs !== 1'b1);
		chk("ais", n, 0);
		wloa(1'b0);
		rd(`A_STAT);
		chk("recovery", v[`S_FARST], 1'b1);
		repeat (4096) @(posedge i_clk);
		chk("service word", svc, 8'hDF);
		chk("fas word", fas, 8'h9B);
		$display("test alignment done");
		for (int t = 3; t <= 4; t++) begin
			wr(`A_CTRL, 32'h0000_0018 | (t - 3));
			rd(`A_FEC);
			f0 = v;
			fas_ok <= 1'b0;
			wloa(1'b1);
			chk("loss delay", n > (t - 1) * 2048 && n <= t * 2048 + 40, 1);
			rd(`A_STAT);
			chk("loss sticky", v[1:0], 2'h3);
			repeat (4096) @(posedge i_clk);
			rd(`A_FEC);
			chk("fec", v, f0 + t);
			chk("auto alarm", svc, 8'hFF);
			fas_ok <= 1'b1;
			wloa(1'b0);
			$display("test threshold %0d done", t);
		end
		wr(`A_CTRL, 32'h0000_001A);
		svc_ok <= 1'b0;
		repeat (8192) @(posedge i_clk);
		chk("service loss off", loa, 1'b0);
		wr(`A_CTRL, 32'h0000_0018);
		wloa(1'b1);
		svc_ok <= 1'b1;
		wloa(1'b0);
		wr(`A_CTRL, 32'h0000_0038);
		wloa(1'b1);
		chk("force delay", n <= 4, 1);
		wloa(1'b0);
		$display("test resync done");
		wr(`A_TXSW, 32'h0000_04FB);
		repeat (4096) @(posedge i_clk);
		chk("alarm from input", svc, 8'hFF);
		chk("fas kept", fas, 8'h9B);
		i_sys <= 1'b0;
		wr(`A_CTRL, 32'h0000_0058);
		repeat (4096) @(posedge i_clk);
		chk("ts0 from input", {svc, fas}, 16'h0000);
		rd(`A_STAT);
		chk("ones fault", v[4:3], 2'h3);
		short_on <= 1'b1;
		repeat (16) @(posedge i_clk);
		chk("drive off", {oe_n, la, lb}, 3'h4);
		rd(`A_STAT);
		chk("short", v[`S_SHORT], 1'b1);
		short_on <= 1'b0;
		wr(`A_STAT, 32'h0000_0020);
		repeat (2) @(posedge i_clk);
		chk("drive on", oe_n, 1'b0);
		$display("test transmit done");
		test_done;
	end
endmodule
`default_nettype wire
